// >>> design/mirror_array_pkg.sv
package mirror_array_pkg;

  // Active array size.
  localparam int COLS = 1920;
  localparam int ROWS = 1080;
  localparam int ROW_W = 11;

  // Load interface: four channels, each carrying one half-word per edge.
  localparam int CHANNELS = 4;
  localparam int CH_W = 16;
  localparam int EDGE_W = 2 * CH_W;
  localparam int BEAT_W = CHANNELS * EDGE_W;
  localparam int BEATS_PER_ROW = COLS / BEAT_W;
  localparam int BEAT_CNT_W = 4;
  localparam int SHIFT_W = COLS - BEAT_W;

  // Reset groups are bands of whole rows.
  localparam int GROUP_ROWS = 72;
  localparam int GROUPS = ROWS / GROUP_ROWS;
  localparam int GROUP_W = 4;
  localparam int GROUP_CNT_W = 7;

  // Load buffer depth and the count width that goes with it.
  localparam int BUF_DEPTH = 2;
  localparam int BUF_CNT_W = 2;

  // Reset value of all control state.
  localparam logic STATE_RESET = 1'b0;

  typedef enum logic {
    COPY_IDLE,
    COPY_RUN
  } copy_state_t;

endpackage

// >>> design/bit_row_mem.sv
`timescale 1ns/1ps

// Simple dual-port row memory; read data come out of a register.
module bit_row_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int ADDR_W = 2
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rstn_in,
  // Write port.
  input wire logic wr_en_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  // Read port.
  input wire logic rd_en_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);

  logic [WIDTH-1:0] mem [DEPTH];

  // The array itself has no reset, so it maps onto block memory.
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // Registered read; a read of the row being written returns old data.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out <= '0;
    end else if (rd_en_in) begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule

// >>> design/mirror_array.sv
`timescale 1ns/1ps

module mirror_array
  import mirror_array_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rstn_in,
  // Pixel load stream, one beat of all four channels per cycle.
  input wire logic load_valid_in,
  input wire logic load_first_in,
  input wire logic [CH_W-1:0] chan_a_rise_in,
  input wire logic [CH_W-1:0] chan_a_fall_in,
  input wire logic [CH_W-1:0] chan_b_rise_in,
  input wire logic [CH_W-1:0] chan_b_fall_in,
  input wire logic [CH_W-1:0] chan_c_rise_in,
  input wire logic [CH_W-1:0] chan_c_fall_in,
  input wire logic [CH_W-1:0] chan_d_rise_in,
  input wire logic [CH_W-1:0] chan_d_fall_in,
  output logic load_ready_out,
  // Mirror group reset request.
  input wire logic mirror_group_reset_in,
  input wire logic [GROUP_W-1:0] reset_group_in,
  output logic reset_busy_out,
  // Mirror state view, one row at a time.
  input wire logic view_req_in,
  input wire logic [ROW_W-1:0] view_row_in,
  output logic view_valid_out,
  output logic [COLS-1:0] mirror_true_out,
  output logic [COLS-1:0] cell_inverse_output_out
);

  typedef struct packed {
    logic [BUF_DEPTH-1:0][BEAT_W:0] buf_data;
    logic buf_wr_ptr;
    logic buf_rd_ptr;
    logic [BUF_CNT_W-1:0] buf_count;
    logic buf_ready;
    logic [SHIFT_W-1:0] shift;
    logic [BEAT_CNT_W-1:0] beat_cnt;
    logic [ROW_W-1:0] load_row;
    copy_state_t copy_st;
    logic [ROW_W-1:0] copy_base;
    logic [GROUP_CNT_W-1:0] copy_cnt;
    logic wr_pend;
    logic [ROW_W-1:0] wr_addr;
    logic busy;
    logic view_pend;
    logic view_valid;
    logic [COLS-1:0] view_true;
    logic [COLS-1:0] view_inv;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [CHANNELS-1:0][EDGE_W-1:0] chan_word;
  logic [BEAT_W-1:0] beat_in;
  logic cell_wr_en;
  logic [ROW_W-1:0] cell_wr_addr;
  logic [COLS-1:0] cell_wr_data;
  logic cell_rd_en;
  logic [ROW_W-1:0] cell_rd_addr;
  logic [COLS-1:0] cell_rd_data;
  logic mirror_rd_en;
  logic [COLS-1:0] mirror_rd_data;

  // Rising and falling half-words of each channel form one beat.
  assign chan_word[0] = {chan_a_fall_in, chan_a_rise_in};
  assign chan_word[1] = {chan_b_fall_in, chan_b_rise_in};
  assign chan_word[2] = {chan_c_fall_in, chan_c_rise_in};
  assign chan_word[3] = {chan_d_fall_in, chan_d_rise_in};
  assign beat_in = chan_word;

  // Cell storage: written by the load path, read only by a reset pulse.
  bit_row_mem #(
    .WIDTH(COLS),
    .DEPTH(ROWS),
    .ADDR_W(ROW_W)
  ) u_cell_mem (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .wr_en_in(cell_wr_en),
    .wr_addr_in(cell_wr_addr),
    .wr_data_in(cell_wr_data),
    .rd_en_in(cell_rd_en),
    .rd_addr_in(cell_rd_addr),
    .rd_data_out(cell_rd_data)
  );

  // Applied mirror state: written only by a reset pulse.
  bit_row_mem #(
    .WIDTH(COLS),
    .DEPTH(ROWS),
    .ADDR_W(ROW_W)
  ) u_mirror_mem (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .wr_en_in(state_reg.wr_pend),
    .wr_addr_in(state_reg.wr_addr),
    .wr_data_in(cell_rd_data),
    .rd_en_in(mirror_rd_en),
    .rd_addr_in(view_row_in),
    .rd_data_out(mirror_rd_data)
  );

  // Next-state logic for buffer, row assembly, reset pulse and view.
  always_comb begin
    logic fill;
    logic drain;
    logic first;
    logic [BEAT_W-1:0] head;
    logic [BEAT_CNT_W-1:0] idx;
    logic [ROW_W-1:0] row;
    logic [ROW_W-1:0] rd_row;
    state_next = state_reg;
    fill = load_valid_in && state_reg.buf_ready;
    // Loads stall while a reset pulse copies rows, so the buffer fills.
    drain = (state_reg.buf_count != '0) && (state_reg.copy_st == COPY_IDLE);
    first = state_reg.buf_data[state_reg.buf_rd_ptr][BEAT_W];
    head = state_reg.buf_data[state_reg.buf_rd_ptr][BEAT_W-1:0];
    idx = first ? '0 : state_reg.beat_cnt;
    row = first ? '0 : state_reg.load_row;
    rd_row = state_reg.copy_base + ROW_W'(state_reg.copy_cnt);
    cell_wr_en = 1'b0;
    cell_wr_addr = row;
    cell_wr_data = {head, state_reg.shift};
    cell_rd_en = 1'b0;
    cell_rd_addr = rd_row;
    mirror_rd_en = view_req_in;

    // Two-entry buffer between the load pins and row assembly.
    if (fill) begin
      state_next.buf_data[state_reg.buf_wr_ptr] = {load_first_in, beat_in};
      state_next.buf_wr_ptr = ~state_reg.buf_wr_ptr;
    end
    if (drain) begin
      state_next.buf_rd_ptr = ~state_reg.buf_rd_ptr;
      if (idx == BEAT_CNT_W'(BEATS_PER_ROW - 1)) begin
        cell_wr_en = 1'b1;
        state_next.beat_cnt = '0;
        state_next.load_row = (row == ROW_W'(ROWS - 1)) ? '0 :
                              row + ROW_W'(1);
      end else begin
        state_next.shift = {head, state_reg.shift[SHIFT_W-1:BEAT_W]};
        state_next.beat_cnt = idx + BEAT_CNT_W'(1);
        state_next.load_row = row;
      end
    end
    state_next.buf_count = state_reg.buf_count + BUF_CNT_W'(fill) -
                           BUF_CNT_W'(drain);
    state_next.buf_ready = state_next.buf_count != BUF_CNT_W'(BUF_DEPTH);

    // Reset pulse: copy every row of the chosen group to mirror state.
    state_next.wr_pend = 1'b0;
    unique case (state_reg.copy_st)
      COPY_IDLE: begin
        // The last row's write must land before a new pulse is taken.
        if (mirror_group_reset_in && !state_reg.wr_pend &&
            (reset_group_in < GROUP_W'(GROUPS))) begin
          state_next.copy_st = COPY_RUN;
          state_next.copy_base = ROW_W'(reset_group_in) *
                                 ROW_W'(GROUP_ROWS);
          state_next.copy_cnt = '0;
        end
      end
      COPY_RUN: begin
        cell_rd_en = 1'b1;
        state_next.wr_pend = 1'b1;
        state_next.wr_addr = rd_row;
        if (state_reg.copy_cnt == GROUP_CNT_W'(GROUP_ROWS - 1)) begin
          state_next.copy_st = COPY_IDLE;
        end else begin
          state_next.copy_cnt = state_reg.copy_cnt + GROUP_CNT_W'(1);
        end
      end
    endcase
    state_next.busy = (state_next.copy_st == COPY_RUN) ||
                      state_next.wr_pend;

    // View: a 1 shows as on (true high), a 0 as off (inverse high).
    state_next.view_pend = view_req_in && (view_row_in < ROW_W'(ROWS));
    state_next.view_valid = state_reg.view_pend;
    if (state_reg.view_pend) begin
      state_next.view_true = mirror_rd_data;
      state_next.view_inv = ~mirror_rd_data;
    end
  end

  // All state registers in one place.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= {$bits(state_t){STATE_RESET}};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state register.
  assign load_ready_out = state_reg.buf_ready;
  assign reset_busy_out = state_reg.busy;
  assign view_valid_out = state_reg.view_valid;
  assign mirror_true_out = state_reg.view_true;
  assign cell_inverse_output_out = state_reg.view_inv;

endmodule

// >>> tb/frame_pat_pkg.sv
package frame_pat_pkg;
  // Half h of a beat: fill flag, h, row low byte, beat number.
  function automatic logic [127:0] pat(int r, int k, logic f);
    for (int h = 0; h < 8; h++) pat[h*16+:16] = {f, 3'(h), 8'(r), 4'(k)};
  endfunction
endpackage

// >>> tb/display_ctrl_model.sv
`timescale 1ns/1ps
// Controller stand-in; a frame with fill high is sent with idle gaps.
module display_ctrl_model
  import frame_pat_pkg::*;
(
  // Clock, reset and command.
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic go_in,
  input wire logic fill_in,
  // Beat stream.
  input wire logic ready_in,
  output logic valid_out,
  output logic first_out,
  output logic [127:0] beat_out,
  output logic done_out
);
  logic run;
  logic [14:0] idx;
  wire logic last = (idx == 15'h3f48);
  // A beat holds until taken; released data lines show the inverse.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      run <= 1'b0;
      idx <= '0;
      valid_out <= 1'b0;
      first_out <= 1'b0;
      beat_out <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (go_in && !run) begin
        run <= 1'b1;
        idx <= '0;
      end else if (run && (!valid_out || ready_in)) begin
        if (last || (fill_in && valid_out)) begin
          valid_out <= 1'b0;
          beat_out <= ~beat_out;
          run <= !last;
          done_out <= last;
        end else begin
          valid_out <= 1'b1;
          first_out <= (idx == 15'h0);
          beat_out <= pat(idx / 15, idx % 15, fill_in);
          idx <= idx + 15'h1;
        end
      end
    end
  end
endmodule

// >>> tb/mirror_array_sva.sv
`timescale 1ns/1ps
// Port-level checks on the mirror array.
module mirror_array_sva
  import mirror_array_pkg::*;
(
  // Watched ports.
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic mirror_group_reset_in,
  input wire logic [GROUP_W-1:0] reset_group_in,
  input wire logic reset_busy_out,
  input wire logic view_req_in,
  input wire logic [ROW_W-1:0] view_row_in,
  input wire logic view_valid_out,
  input wire logic [COLS-1:0] mirror_true_out,
  input wire logic [COLS-1:0] cell_inverse_output_out
);
  logic [6:0] busy_cnt_reg;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Counts the cycles of the current pulse.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) busy_cnt_reg <= 7'h0;
    else busy_cnt_reg <= reset_busy_out ? busy_cnt_reg + 7'h1 : 7'h0;
  end
  inverse_pair_a: assert property (view_valid_out |->
    cell_inverse_output_out == ~mirror_true_out) else $error("Bad inverse.");
  view_lat_a: assert property (view_req_in && view_row_in < ROWS
    |-> ##2 view_valid_out) else $error("No view answer.");
  view_bad_a: assert property (view_req_in && view_row_in >= ROWS
    |-> ##2 !view_valid_out) else $error("Bad row answered.");
  valid_src_a: assert property (view_valid_out |->
    $past(view_req_in, 2)) else $error("Answer without request.");
  view_hold_a: assert property (!view_valid_out |->
    $stable(mirror_true_out)) else $error("Mirror state moved.");
  busy_rise_a: assert property (mirror_group_reset_in &&
    !reset_busy_out && reset_group_in != 4'hf |=> reset_busy_out)
    else $error("Pulse not started.");
  busy_len_a: assert property ($fell(reset_busy_out) |->
    busy_cnt_reg == 7'h49) else $error("Wrong pulse length.");
  group_skip_a: assert property (mirror_group_reset_in &&
    !reset_busy_out && reset_group_in == 4'hf |=> !reset_busy_out)
    else $error("Group 15 accepted.");
  // Main scenarios reached.
  cover property (view_valid_out);
  cover property ($fell(reset_busy_out));
  cover property (view_req_in && view_row_in >= ROWS);
endmodule

bind mirror_array mirror_array_sva chk_u (.clk_in, .rstn_in,
  .mirror_group_reset_in, .reset_group_in, .reset_busy_out, .view_req_in,
  .view_row_in, .view_valid_out, .mirror_true_out, .cell_inverse_output_out);

// >>> tb/test_mirror_array.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  miscompares++; $display("[ERR] %0t %h %h", $time, a, b); end end
module test_mirror_array;
  import mirror_array_pkg::*;
  import frame_pat_pkg::*;
  logic clk_in, rstn_in = 1'b0, go = 1'b0, fill = 1'b0, done, valid, first;
  logic ready, greq = 1'b0, vreq = 1'b0, busy, vvalid;
  logic [GROUP_W-1:0] grp = 4'h0;
  logic [ROW_W-1:0] vrow = 11'h0;
  logic [127:0] beat;
  logic [COLS-1:0] mt, mi;
  int miscompares = 0;
  int total_checks = 0;
  mirror_array dut_u (.clk_in, .rstn_in, .load_valid_in(valid),
    .load_first_in(first), .chan_a_rise_in(beat[15:0]),
    .chan_a_fall_in(beat[31:16]), .chan_b_rise_in(beat[47:32]),
    .chan_b_fall_in(beat[63:48]), .chan_c_rise_in(beat[79:64]),
    .chan_c_fall_in(beat[95:80]), .chan_d_rise_in(beat[111:96]),
    .chan_d_fall_in(beat[127:112]), .load_ready_out(ready),
    .mirror_group_reset_in(greq), .reset_group_in(grp),
    .reset_busy_out(busy), .view_req_in(vreq), .view_row_in(vrow),
    .view_valid_out(vvalid), .mirror_true_out(mt),
    .cell_inverse_output_out(mi));
  display_ctrl_model ctrl_u (.clk_in, .rstn_in, .go_in(go), .fill_in(fill),
    .ready_in(ready), .valid_out(valid), .first_out(first),
    .beat_out(beat), .done_out(done));
  // Free-running 100 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task end_of_test();
    $display("checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [COLS-1:0] exp_row(int r, logic f);
    for (int k = 0; k < BEATS_PER_ROW; k++)
      exp_row[k*BEAT_W+:BEAT_W] = pat(r, k, f);
  endfunction
  task load(input logic f);
    @(posedge clk_in);
    go <= 1'b1;
    fill <= f;
    @(posedge clk_in);
    go <= 1'b0;
    for (int i = 0; i < 40000 && done !== 1'b1; i++) @(negedge clk_in);
    `CHK(done, 1'b1)
    repeat (5) @(posedge clk_in);
  endtask
  task pulse(input logic [GROUP_W-1:0] g, input logic exp);
    @(posedge clk_in);
    greq <= 1'b1;
    grp <= g;
    @(posedge clk_in);
    greq <= 1'b0;
    @(posedge clk_in);
    @(negedge clk_in);
    `CHK(busy, exp)
    for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk_in);
    `CHK(busy, 1'b0)
  endtask
  task view(input int r, input logic ok, input logic [COLS-1:0] e);
    @(posedge clk_in);
    vreq <= 1'b1;
    vrow <= ROW_W'(r);
    @(posedge clk_in);
    vreq <= 1'b0;
    // The answer stands for the one cycle after the next edge.
    @(posedge clk_in);
    @(negedge clk_in);
    `CHK(vvalid, ok)
    if (ok) `CHK(mt, e)
    if (ok) `CHK(mi, ~e)
  endtask
  // Slow first frame, then band 2 is applied and read back.
  task apply_frame();
    load(1'b1);
    pulse(4'h2, 1'b1);
    view(144, 1'b1, exp_row(144, 1'b1));
    view(215, 1'b1, exp_row(215, 1'b1));
    view(1080, 1'b0, '0);
    pulse(4'hf, 1'b0);
  endtask
  // A frame loads under a pulse; mirrors move only on later pulses.
  task hold_frame();
    fork
      load(1'b0);
      pulse(4'h2, 1'b1);
      // Cell writes are held off while the pulse copies, so loads stall.
      begin
        repeat (10) @(posedge clk_in);
        @(negedge clk_in);
        `CHK(ready, 1'b0)
      end
    join
    view(144, 1'b1, exp_row(144, 1'b1));
    pulse(4'h2, 1'b1);
    view(144, 1'b1, exp_row(144, 1'b0));
    pulse(4'he, 1'b1);
    view(1079, 1'b1, exp_row(1079, 1'b0));
  endtask
  // Main sequence.
  initial begin
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    apply_frame();
    hold_frame();
    end_of_test();
  end
  // Cuts a hung run short.
  initial begin
    repeat (90000) @(posedge clk_in);
    miscompares++;
    end_of_test();
  end
endmodule
